// ==== core/ifd_cfg.svh ====
`ifndef IFD_CFG_SVH
`define IFD_CFG_SVH

// Register byte addresses
`define IFD_ADDR_CTRL 12'h000
`define IFD_ADDR_FLAGS 12'h004
`define IFD_ADDR_STATUS 12'h008
`define IFD_ADDR_INSN 12'h00C
`define IFD_ADDR_RESULT 12'h010
`define IFD_ADDR_COUNT 12'h014
`define IFD_CTRL_RESET 1'h0
`define IFD_FLAGS_RESET 4'h0

// Flag bit positions in the flag register
`define IFD_FLG_Z 0
`define IFD_FLG_S 1
`define IFD_FLG_OV 2
`define IFD_FLG_CY 3

// Field positions, first halfword
`define IFD_OPC_HI 15
`define IFD_OPC_LO 10
`define IFD_R2_HI 9
`define IFD_R2_LO 5
`define IFD_R1_HI 4
`define IFD_R1_LO 0
`define IFD_BOP_HI 15
`define IFD_BOP_LO 13
`define IFD_CND_HI 12
`define IFD_CND_LO 9
`define IFD_BDS_HI 8
`define IFD_BDS_LO 1
`define IFD_SUB1 0
// Field positions, second halfword of a long word
`define IFD_UP_HI 31
`define IFD_UP_LO 16
`define IFD_R3_HI 31
`define IFD_R3_LO 27
`define IFD_SUB6_HI 21
`define IFD_SUB6_LO 16

// Opcode map
`define IFD_BOP_BRANCH 3'h4
`define IFD_OPC_NOOP0 6'h1A
`define IFD_OPC_NOOP1 6'h1B
`define IFD_OPC_ADD_RR 6'h01
`define IFD_OPC_ADD_IMM 6'h11
`define IFD_OPC_ADD_WIDE 6'h29
`define IFD_OPC_JUMP_LO 6'h28
`define IFD_OPC_JUMP_HI 6'h2B
`define IFD_OPC_TRI_HI 6'h2F
`define IFD_OPC_LDST_HI 6'h3B
`define IFD_OPC_EXT_HI 6'h3D
`define IFD_OPC_II_LO 6'h10

// Condition codes
`define IFD_CC_V 4'h0
`define IFD_CC_C 4'h1
`define IFD_CC_Z 4'h2
`define IFD_CC_NH 4'h3
`define IFD_CC_N 4'h4
`define IFD_CC_T 4'h5
`define IFD_CC_LT 4'h6
`define IFD_CC_LE 4'h7
`define IFD_CC_NV 4'h8
`define IFD_CC_NC 4'h9
`define IFD_CC_NZ 4'hA
`define IFD_CC_H 4'hB
`define IFD_CC_P 4'hC
`define IFD_CC_F 4'hD
`define IFD_CC_GE 4'hE
`define IFD_CC_GT 4'hF

`endif

// ==== core/ifd_pkg.sv ====
package ifd_pkg;
	typedef enum logic [1:0] {
		IFD_FIRST = 2'b01,
		IFD_SECOND = 2'b10
	} ifd_state_e;
	typedef enum logic [3:0] {
		IFD_FMT_I = 4'h1,
		IFD_FMT_II = 4'h2,
		IFD_FMT_III = 4'h3,
		IFD_FMT_IV = 4'h4,
		IFD_FMT_V = 4'h5,
		IFD_FMT_VI = 4'h6,
		IFD_FMT_VII = 4'h7,
		IFD_FMT_VIII = 4'h8,
		IFD_FMT_IX = 4'h9
	} ifd_fmt_e;
endpackage : ifd_pkg

// ==== core/ifd_decoder.sv ====
`timescale 1ns/1ns
`include "ifd_cfg.svh"
module ifd_decoder
	import ifd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_half,
	input wire logic [31:0] fetch_pc,
	output logic fetch_ready,
	output logic dec_valid,
	output logic [3:0] dec_format,
	output logic dec_long,
	output logic [5:0] dec_opcode,
	output logic [4:0] source_gpr_field,
	output logic [4:0] second_gpr_field,
	output logic [4:0] third_gpr_field,
	output logic [5:0] dec_sub_op,
	output logic [3:0] dec_cond,
	output logic [31:0] dec_immediate,
	output logic dec_reserved_err,
	input wire logic [31:0] src_gpr_data,
	input wire logic [31:0] second_gpr_data,
	output logic ex_valid,
	output logic [31:0] ex_result,
	output logic ex_write,
	output logic [4:0] ex_write_sel,
	output logic [31:0] ex_mem_addr,
	output logic ex_mem_valid,
	output logic ex_branch_taken,
	output logic [31:0] ex_branch_target,
	output logic [3:0] flags
);

	// Decode stage state
	ifd_state_e state_q, state_d;
	logic [15:0] low_q, low_d;
	logic [31:0] pc_q, pc_d;
	logic fetch_ready_q, fetch_ready_d;
	logic dec_valid_q, dec_valid_d;
	logic [3:0] fmt_q, fmt_d;
	logic long_q, long_d;
	logic [5:0] opc_q, opc_d;
	logic [4:0] r1_q, r1_d, r2_q, r2_d, r3_q, r3_d;
	logic [5:0] sub_q, sub_d;
	logic [3:0] cond_q, cond_d;
	logic [31:0] imm_q, imm_d;
	logic [31:0] disp_q, disp_d;
	logic rsv_q, rsv_d;
	logic [31:0] insn_q, insn_d;
	logic [31:0] count_q, count_d;
	logic ctrl_en_q, ctrl_en_d;
	logic apb_wr, apb_flag_wr;

	logic [31:0] word;
	logic [5:0] opc_c;
	logic [3:0] fmt_c;
	logic take;

	// Instruction class from the opcode alone
	function automatic logic [3:0] fmt_of(input logic [5:0] op);
		if (op[5:3] == `IFD_BOP_BRANCH)
			fmt_of = IFD_FMT_III;
		else if (op == `IFD_OPC_NOOP0 || op == `IFD_OPC_NOOP1)
			fmt_of = IFD_FMT_IX;
		else if (op < `IFD_OPC_II_LO)
			fmt_of = IFD_FMT_I;
		else if (op < `IFD_OPC_JUMP_LO)
			fmt_of = IFD_FMT_II;
		else if (op <= `IFD_OPC_JUMP_HI)
			fmt_of = (op == `IFD_OPC_ADD_WIDE) ? IFD_FMT_V : IFD_FMT_IV;
		else if (op <= `IFD_OPC_TRI_HI)
			fmt_of = IFD_FMT_V;
		else if (op <= `IFD_OPC_LDST_HI)
			fmt_of = IFD_FMT_VI;
		else if (op <= `IFD_OPC_EXT_HI)
			fmt_of = IFD_FMT_VII;
		else
			fmt_of = IFD_FMT_VIII;
	endfunction : fmt_of

	always_comb
	begin
		state_d = state_q;
		low_d = low_q;
		pc_d = pc_q;
		dec_valid_d = 1'b0;
		fmt_d = fmt_q;
		long_d = long_q;
		opc_d = opc_q;
		r1_d = r1_q;
		r2_d = r2_q;
		r3_d = r3_q;
		sub_d = sub_q;
		cond_d = cond_q;
		imm_d = imm_q;
		disp_d = disp_q;
		rsv_d = rsv_q;
		insn_d = insn_q;
		count_d = count_q;
		take = fetch_valid && fetch_ready_q;
		word = (state_q == IFD_SECOND) ? {fetch_half, low_q} : {16'h0000, fetch_half};
		opc_c = word[`IFD_OPC_HI:`IFD_OPC_LO];
		fmt_c = fmt_of(opc_c);
		fetch_ready_d = ctrl_en_q;
		unique case (state_q)
			IFD_FIRST:
			begin
				pc_d = fetch_pc;
				low_d = fetch_half;
			end
			IFD_SECOND:
			begin
			end
		endcase
		if (take)
		begin
			if (state_q == IFD_FIRST && fmt_c >= IFD_FMT_IV && fmt_c <= IFD_FMT_VIII)
				state_d = IFD_SECOND;
			else
			begin
				state_d = IFD_FIRST;
				dec_valid_d = 1'b1;
				count_d = count_q + 32'h0000_0001;
				insn_d = word;
				fmt_d = fmt_c;
				long_d = (state_q == IFD_SECOND);
				opc_d = opc_c;
				r1_d = word[`IFD_R1_HI:`IFD_R1_LO];
				r2_d = word[`IFD_R2_HI:`IFD_R2_LO];
				r3_d = 5'h00;
				sub_d = 6'h00;
				cond_d = 4'h0;
				imm_d = 32'h0000_0000;
				disp_d = 32'h0000_0000;
				rsv_d = 1'b0;
				unique case (fmt_c)
					IFD_FMT_I:
					begin
					end
					IFD_FMT_II:
					begin
						r1_d = 5'h00;
						imm_d = {{27{word[4]}}, word[4:0]};
					end
					IFD_FMT_III:
					begin
						opc_d = {word[`IFD_BOP_HI:`IFD_BOP_LO], 3'h0};
						cond_d = word[`IFD_CND_HI:`IFD_CND_LO];
						sub_d = {5'h00, word[`IFD_SUB1]};
						r1_d = 5'h00;
						r2_d = 5'h00;
						disp_d = {{23{word[`IFD_BDS_HI]}}, word[`IFD_BDS_HI:`IFD_BDS_LO], 1'b0};
					end
					IFD_FMT_IV:
					begin
						r1_d = 5'h00;
						r2_d = 5'h00;
						disp_d = {{6{word[9]}}, word[9:0], word[31:17], 1'b0};
					end
					IFD_FMT_V:
						imm_d = {{16{word[31]}}, word[`IFD_UP_HI:`IFD_UP_LO]};
					IFD_FMT_VI:
						disp_d = {{16{word[31]}}, word[`IFD_UP_HI:`IFD_UP_LO]};
					IFD_FMT_VII:
					begin
						sub_d = word[`IFD_SUB6_HI:`IFD_SUB6_LO];
						rsv_d = (word[26:22] != 5'h00);
					end
					IFD_FMT_VIII:
					begin
						sub_d = word[`IFD_SUB6_HI:`IFD_SUB6_LO];
						r3_d = word[`IFD_R3_HI:`IFD_R3_LO];
						rsv_d = (word[26:22] != 5'h00);
					end
					IFD_FMT_IX:
					begin
						r1_d = 5'h00;
						r2_d = 5'h00;
						sub_d = {5'h00, word[`IFD_SUB1]};
						rsv_d = (word[9:1] != 9'h000);
					end
					default:
					begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= IFD_FIRST;
			low_q <= 16'h0000;
			pc_q <= 32'h0000_0000;
			fetch_ready_q <= 1'b0;
			dec_valid_q <= 1'b0;
			fmt_q <= 4'h0;
			long_q <= 1'b0;
			opc_q <= 6'h00;
			r1_q <= 5'h00;
			r2_q <= 5'h00;
			r3_q <= 5'h00;
			sub_q <= 6'h00;
			cond_q <= 4'h0;
			imm_q <= 32'h0000_0000;
			disp_q <= 32'h0000_0000;
			rsv_q <= 1'b0;
			insn_q <= 32'h0000_0000;
			count_q <= 32'h0000_0000;
		end
		else
		begin
			state_q <= state_d;
			low_q <= low_d;
			pc_q <= pc_d;
			fetch_ready_q <= fetch_ready_d;
			dec_valid_q <= dec_valid_d;
			fmt_q <= fmt_d;
			long_q <= long_d;
			opc_q <= opc_d;
			r1_q <= r1_d;
			r2_q <= r2_d;
			r3_q <= r3_d;
			sub_q <= sub_d;
			cond_q <= cond_d;
			imm_q <= imm_d;
			disp_q <= disp_d;
			rsv_q <= rsv_d;
			insn_q <= insn_d;
			count_q <= count_d;
		end
	end

	// Execute stage; register file answers the selects combinationally
	logic ex_valid_q, ex_valid_d;
	logic [31:0] res_q, res_d;
	logic wr_q, wr_d;
	logic [4:0] wsel_q, wsel_d;
	logic [31:0] maddr_q, maddr_d;
	logic mval_q, mval_d;
	logic btk_q, btk_d;
	logic [31:0] btg_q, btg_d;
	logic [3:0] flg_q, flg_d;

	logic [31:0] add_a, add_b;
	logic [32:0] sum;
	logic is_add, cy, ov, sg, zf, hit;

	always_comb
	begin
		ex_valid_d = dec_valid_q;
		res_d = res_q;
		wr_d = 1'b0;
		wsel_d = wsel_q;
		maddr_d = maddr_q;
		mval_d = 1'b0;
		btk_d = 1'b0;
		btg_d = btg_q;
		flg_d = flg_q;
		cy = flg_q[`IFD_FLG_CY];
		ov = flg_q[`IFD_FLG_OV];
		sg = flg_q[`IFD_FLG_S];
		zf = flg_q[`IFD_FLG_Z];
		add_a = second_gpr_data;
		add_b = src_gpr_data;
		is_add = 1'b0;
		if (fmt_q == IFD_FMT_II && opc_q == `IFD_OPC_ADD_IMM)
		begin
			add_b = imm_q;
			is_add = 1'b1;
		end
		else if (fmt_q == IFD_FMT_I && opc_q == `IFD_OPC_ADD_RR)
			is_add = 1'b1;
		else if (fmt_q == IFD_FMT_V && opc_q == `IFD_OPC_ADD_WIDE)
		begin
			add_a = src_gpr_data;
			add_b = imm_q;
			is_add = 1'b1;
		end
		sum = {1'b0, add_a} + {1'b0, add_b};
		// Condition tests on flags before this instruction
		unique case (cond_q)
			`IFD_CC_V: hit = ov;
			`IFD_CC_C: hit = cy;
			`IFD_CC_Z: hit = zf;
			`IFD_CC_NH: hit = cy | zf;
			`IFD_CC_N: hit = sg;
			`IFD_CC_T: hit = 1'b1;
			`IFD_CC_LT: hit = sg ^ ov;
			`IFD_CC_LE: hit = (sg ^ ov) | zf;
			`IFD_CC_NV: hit = ~ov;
			`IFD_CC_NC: hit = ~cy;
			`IFD_CC_NZ: hit = ~zf;
			`IFD_CC_H: hit = ~(cy | zf);
			`IFD_CC_P: hit = ~sg;
			`IFD_CC_F: hit = 1'b0;
			`IFD_CC_GE: hit = ~(sg ^ ov);
			`IFD_CC_GT: hit = ~((sg ^ ov) | zf);
		endcase
		if (dec_valid_q)
		begin
			if (is_add)
			begin
				res_d = sum[31:0];
				wr_d = 1'b1;
				wsel_d = r2_q;
				flg_d[`IFD_FLG_CY] = sum[32];
				flg_d[`IFD_FLG_OV] = (add_a[31] == add_b[31]) && (sum[31] != add_a[31]);
				flg_d[`IFD_FLG_S] = sum[31];
				flg_d[`IFD_FLG_Z] = (sum[31:0] == 32'h0000_0000);
			end
			else if (apb_flag_wr)
				flg_d = pwdata[3:0];
			if (fmt_q == IFD_FMT_VI)
			begin
				maddr_d = src_gpr_data + disp_q;
				mval_d = 1'b1;
			end
			if (fmt_q == IFD_FMT_III)
			begin
				btk_d = hit;
				btg_d = pc_q + disp_q;
			end
			else if (fmt_q == IFD_FMT_IV)
			begin
				btk_d = 1'b1;
				btg_d = pc_q + disp_q;
			end
		end
		else if (apb_flag_wr)
			flg_d = pwdata[3:0];
		ctrl_en_d = ctrl_en_q;
		if (apb_wr && paddr == `IFD_ADDR_CTRL)
			ctrl_en_d = pwdata[0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ex_valid_q <= 1'b0;
			res_q <= 32'h0000_0000;
			wr_q <= 1'b0;
			wsel_q <= 5'h00;
			maddr_q <= 32'h0000_0000;
			mval_q <= 1'b0;
			btk_q <= 1'b0;
			btg_q <= 32'h0000_0000;
			flg_q <= `IFD_FLAGS_RESET;
			ctrl_en_q <= `IFD_CTRL_RESET;
		end
		else
		begin
			ex_valid_q <= ex_valid_d;
			res_q <= res_d;
			wr_q <= wr_d;
			wsel_q <= wsel_d;
			maddr_q <= maddr_d;
			mval_q <= mval_d;
			btk_q <= btk_d;
			btg_q <= btg_d;
			flg_q <= flg_d;
			ctrl_en_q <= ctrl_en_d;
		end
	end

	// APB slave: one wait state, answer from flops
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;

	always_comb
	begin
		pready_d = psel && penable && !pready_q;
		apb_wr = psel && penable && pready_q && pwrite && !pslverr_q;
		// Hardware flag update wins over a software write
		apb_flag_wr = apb_wr && paddr == `IFD_ADDR_FLAGS;
		pslverr_d = 1'b0;
		prdata_d = 32'h0000_0000;
		if (pready_d)
		begin
			unique case (paddr)
				`IFD_ADDR_CTRL: prdata_d = {31'h0, ctrl_en_q};
				`IFD_ADDR_FLAGS: prdata_d = {28'h0, flg_q};
				`IFD_ADDR_STATUS: prdata_d = {16'h0, rsv_q, 2'h0, long_q, fmt_q, 2'h0, opc_q};
				`IFD_ADDR_INSN: prdata_d = insn_q;
				`IFD_ADDR_RESULT: prdata_d = res_q;
				`IFD_ADDR_COUNT: prdata_d = count_q;
				default: pslverr_d = 1'b1;
			endcase
			if (pwrite)
				prdata_d = 32'h0000_0000;
			if (pwrite && paddr != `IFD_ADDR_CTRL && paddr != `IFD_ADDR_FLAGS)
				pslverr_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else
		begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign fetch_ready = fetch_ready_q;
	assign dec_valid = dec_valid_q;
	assign dec_format = fmt_q;
	assign dec_long = long_q;
	assign dec_opcode = opc_q;
	assign source_gpr_field = r1_q;
	assign second_gpr_field = r2_q;
	assign third_gpr_field = r3_q;
	assign dec_sub_op = sub_q;
	assign dec_cond = cond_q;
	assign dec_immediate = imm_q;
	assign dec_reserved_err = rsv_q;
	assign ex_valid = ex_valid_q;
	assign ex_result = res_q;
	assign ex_write = wr_q;
	assign ex_write_sel = wsel_q;
	assign ex_mem_addr = maddr_q;
	assign ex_mem_valid = mval_q;
	assign ex_branch_taken = btk_q;
	assign ex_branch_target = btg_q;
	assign flags = flg_q;

endmodule : ifd_decoder

// ==== tb/ifd_decoder_asserts.sv ====
`timescale 1ns/1ns
`include "ifd_cfg.svh"
module ifd_decoder_asserts
	import ifd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic fetch_valid,
	input wire logic fetch_ready,
	input wire logic [15:0] fetch_half,
	input wire logic [31:0] fetch_pc,
	input wire logic dec_valid,
	input wire logic [3:0] dec_format,
	input wire logic dec_long,
	input wire logic [4:0] source_gpr_field,
	input wire logic [4:0] second_gpr_field,
	input wire logic [3:0] dec_cond,
	input wire logic [5:0] dec_sub_op,
	input wire logic [31:0] dec_immediate,
	input wire logic [31:0] src_gpr_data,
	input wire logic [31:0] second_gpr_data,
	input wire logic ex_valid,
	input wire logic [31:0] ex_result,
	input wire logic ex_write,
	input wire logic [4:0] ex_write_sel,
	input wire logic ex_mem_valid,
	input wire logic [31:0] ex_mem_addr,
	input wire logic ex_branch_taken,
	input wire logic [31:0] ex_branch_target,
	input wire logic [3:0] flags
);
	logic [15:0] lo_q;
	logic [31:0] pc_q;
	logic hi_q;
	logic [31:0] w;
	logic [31:0] cpc;
	logic [5:0] op;
	logic fin;
	logic br;
	// Own length decode, so a wrong split in the design shows up
	assign w = hi_q ? {fetch_half, lo_q} : {16'h0000, fetch_half};
	assign cpc = hi_q ? pc_q : fetch_pc;
	assign op = w[15:10];
	assign br = op[5:3] == 3'h4;
	assign fin = fetch_valid && fetch_ready && (hi_q || fetch_half[15:10] < 6'h28);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hi_q <= 1'h0;
		else if (fetch_valid && fetch_ready)
		begin
			hi_q <= !hi_q && fetch_half[15:10] >= 6'h28;
			lo_q <= fetch_half;
			pc_q <= fetch_pc;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_len;
		fin |=> dec_valid && dec_long == $past(hi_q) ##1 ex_valid;
	endproperty
	a_len: assert property (p_len)
		else $error("length or timing wrong");
	property p_fmt1;
		fin && op[5:4] == 2'h0 |=> dec_format == IFD_FMT_I && source_gpr_field == $past(w[4:0])
			&& second_gpr_field == $past(w[9:5]);
	endproperty
	a_fmt1: assert property (p_fmt1)
		else $error("reg-reg fields wrong");
	property p_short_immediate;
		fin && op[5:4] == 2'h1 && op[5:1] != 5'h0D |=> dec_format == IFD_FMT_II
			&& dec_immediate == {{27{$past(w[4])}}, $past(w[4:0])};
	endproperty
	a_short_immediate: assert property (p_short_immediate)
		else $error("short immediate wrong");
	property p_cond;
		fin && br |=> dec_format == IFD_FMT_III && dec_cond == $past(w[12:9])
			&& dec_sub_op == {5'h00, $past(w[0])};
	endproperty
	a_cond: assert property (p_cond)
		else $error("branch fields wrong");
	property p_target;
		fin && br |=> ##1 (!ex_branch_taken || ex_branch_target == $past(cpc, 2)
			+ {{23{$past(w[8], 2)}}, $past(w[8:1], 2), 1'h0});
	endproperty
	a_target: assert property (p_target)
		else $error("branch target wrong");
	property p_hold;
		fin && br |=> ##1 $stable(flags);
	endproperty
	a_hold: assert property (p_hold)
		else $error("branch changed flags");
	property p_rr;
		fin && op == `IFD_OPC_ADD_RR |=> ##1 ex_write && ex_write_sel == $past(second_gpr_field)
			&& ex_result == $past(src_gpr_data) + $past(second_gpr_data);
	endproperty
	a_rr: assert property (p_rr)
		else $error("register add wrong");
	property p_wide;
		fin && op == `IFD_OPC_ADD_WIDE |=> ##1 ex_write && ex_write_sel == $past(second_gpr_field)
			&& ex_result == $past(src_gpr_data) + {{16{$past(w[31], 2)}}, $past(w[31:16], 2)};
	endproperty
	a_wide: assert property (p_wide)
		else $error("wide add wrong");
	property p_mem;
		fin && op >= 6'h30 && op <= `IFD_OPC_LDST_HI |=> ##1 ex_mem_valid
			&& ex_mem_addr == $past(src_gpr_data) + {{16{$past(w[31], 2)}}, $past(w[31:16], 2)};
	endproperty
	a_mem: assert property (p_mem)
		else $error("based address wrong");
endmodule : ifd_decoder_asserts
bind ifd_decoder ifd_decoder_asserts ifd_decoder_asserts_i (.*);

// ==== tb/ifd_fetch_model.sv ====
`timescale 1ns/1ns
module ifd_fetch_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic fetch_ready,
	input wire logic slow,
	input wire logic [4:0] source_gpr_field,
	input wire logic [4:0] second_gpr_field,
	output logic fetch_valid,
	output logic [15:0] fetch_half,
	output logic [31:0] fetch_pc,
	output logic [31:0] src_gpr_data,
	output logic [31:0] second_gpr_data
);
	logic [31:0] gpr [32];
	logic [15:0] hq [$];
	logic [31:0] pq [$];
	task automatic put(input logic [31:0] w, input logic lg, input logic [31:0] pc);
		hq.push_back(w[15:0]);
		pq.push_back(pc);
		if (lg)
		begin
			hq.push_back(w[31:16]);
			pq.push_back(pc);
		end
	endtask : put
	assign src_gpr_data = gpr[source_gpr_field];
	assign second_gpr_data = gpr[second_gpr_field];
	// Idle data toggles so a stale half never looks valid
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fetch_valid <= 1'h0;
			fetch_half <= 16'h5A5A;
			fetch_pc <= 32'h0;
		end
		else if (!fetch_valid || fetch_ready)
		begin
			if (hq.size() > 0 && !(slow && fetch_valid))
			begin
				fetch_valid <= 1'h1;
				fetch_half <= hq.pop_front();
				fetch_pc <= pq.pop_front();
			end
			else
			begin
				fetch_valid <= 1'h0;
				fetch_half <= ~fetch_half;
			end
		end
	end
endmodule : ifd_fetch_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`include "ifd_cfg.svh"
module testbench;
	import ifd_pkg::*;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slow = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic pready, pslverr, fetch_ready, dec_valid, dec_long, dec_reserved_err, ex_valid, ex_write;
	logic ex_mem_valid, ex_branch_taken, fetch_valid, tk;
	logic [3:0] dec_format, dec_cond, flags, fp;
	logic [4:0] source_gpr_field, second_gpr_field, third_gpr_field, ex_write_sel;
	logic [5:0] dec_opcode, dec_sub_op;
	logic [15:0] fetch_half;
	logic [31:0] prdata, dec_immediate, ex_result, ex_mem_addr, ex_branch_target, fetch_pc;
	logic [31:0] src_gpr_data, second_gpr_data, res, tg, ma;
	int miscompares = 0, n_compared = 0, cycles = 0;
	ifd_decoder ifd_decoder_i (.*);
	ifd_fetch_model ifd_fetch_model_i (.*);
	always #4 pclk = ~pclk;
	task automatic print_verdict;
		if (miscompares == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	// Hang guard, well above the few hundred cycles needed
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			miscompares++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
		int n;
		logic [31:0] rd;
		logic er;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Answer read mid-cycle, taken at the edge where pready stands high
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		rd = prdata;
		er = pslverr;
		@(posedge pclk);
		psel <= 1'h0;
		penable <= 1'h0;
		if (!w && !e)
			chk(rd, d);
		chk({31'h0, er}, {31'h0, e});
		@(posedge pclk);
	endtask : acc
	task automatic run(input logic [31:0] w, input logic lg, input logic [31:0] pc);
		int n;
		n = 0;
		ifd_fetch_model_i.put(w, lg, pc);
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (ex_valid !== 1'h1 && n < 40);
		tk = ex_branch_taken;
		tg = ex_branch_target;
		res = ex_result;
		ma = ex_mem_addr;
		repeat (2) @(negedge pclk);
		@(posedge pclk);
		chk({31'h0, ex_valid === 1'h0 && n < 40}, 32'h1);
		chk({31'h0, dec_long}, {31'h0, lg});
	endtask : run
	function automatic logic hit(input logic [3:0] c, input logic [3:0] f);
		logic [7:0] t;
		t = {f[1] ^ f[2] | f[0], f[1] ^ f[2], 1'h1, f[1], f[3] | f[0], f[0], f[3], f[2]};
		return t[c[2:0]] ^ c[3];
	endfunction : hit
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		acc(1'h0, `IFD_ADDR_CTRL, 32'h0, 1'h0);
		acc(1'h0, `IFD_ADDR_FLAGS, 32'h0, 1'h0);
		acc(1'h0, 12'h018, 32'h0, 1'h1);
		acc(1'h1, `IFD_ADDR_STATUS, 32'h1, 1'h1);
		acc(1'h1, `IFD_ADDR_CTRL, 32'h1, 1'h0);
		acc(1'h0, `IFD_ADDR_CTRL, 32'h1, 1'h0);
		ifd_fetch_model_i.gpr[1] = 32'h7FFF_FFFF;
		ifd_fetch_model_i.gpr[2] = 32'h1;
		ifd_fetch_model_i.gpr[3] = 32'h1;
		ifd_fetch_model_i.gpr[5] = 32'h10;
		ifd_fetch_model_i.gpr[6] = 32'h1000;
		run(32'h0000_0441, 1'h0, 32'h0);
		chk(res, 32'h8000_0000);
		chk(flags, 4'h6);
		run(32'h0000_447F, 1'h0, 32'h2);
		chk(res, 32'h0);
		chk(flags, 4'h9);
		slow <= 1'h1;
		run(32'h8000_A485, 1'h1, 32'h4);
		chk(res, 32'hFFFF_8010);
		chk(flags, 4'h2);
		acc(1'h0, `IFD_ADDR_RESULT, 32'hFFFF_8010, 1'h0);
		slow <= 1'h0;
		run(32'h0124_C0E6, 1'h1, 32'h8);
		chk(ma, 32'h1124);
		run(32'hFFFC_A3FF, 1'h1, 32'h100);
		chk({tk, tg}, {1'h1, 32'hFC});
		for (int p = 0; p < 2; p++)
		begin
			fp = p ? 4'hA : 4'h5;
			acc(1'h1, `IFD_ADDR_FLAGS, {28'h0, fp}, 1'h0);
			for (int c = 0; c < 16; c++)
			begin
				run({16'h0, 3'h4, c[3:0], 8'h80, 1'h1}, 1'h0, 32'h400);
				chk(tk, hit(c[3:0], fp));
				if (tk === 1'h1)
					chk(tg, 32'h300);
				chk(flags, fp);
			end
		end
		run(32'h0000_6801, 1'h0, 32'h10);
		chk({dec_format, dec_opcode, dec_sub_op, dec_reserved_err}, {IFD_FMT_IX, 6'h1A, 6'h01, 1'h0});
		run(32'h0000_6809, 1'h0, 32'h12);
		chk(dec_reserved_err, 1'h1);
		run(32'h002A_F12A, 1'h1, 32'h20);
		chk({dec_format, dec_sub_op, source_gpr_field}, {IFD_FMT_VII, 6'h2A, 5'h0A});
		run(32'h9815_F92A, 1'h1, 32'h24);
		chk({dec_format, dec_sub_op, third_gpr_field}, {IFD_FMT_VIII, 6'h15, 5'h13});
		chk(second_gpr_field, 5'h09);
		acc(1'h0, `IFD_ADDR_INSN, 32'h9815_F92A, 1'h0);
		acc(1'h0, `IFD_ADDR_COUNT, 32'h29, 1'h0);
		print_verdict();
	end
endmodule : testbench
